/* isv_core_model.sv */
/*
  Behavioural processor core that takes offered requests and runs short routines.
  Assumes request and vector come from registers on the same clock.
*/
`timescale 1ns/1ns
module isv_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [1:0] slow,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  output logic irq_ack,
  output logic irq_return,
  output logic taken,
  output logic [15:0] taken_vector
);
  // ****************
  // Entry and exit
  // ****************
  logic [1:0] wait_reg;
  logic [2:0] svc_reg;

  // No nesting: a new request waits until the routine has returned
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_reg <= 2'h0;
      svc_reg <= 3'h0;
      irq_ack <= 1'h0;
      irq_return <= 1'h0;
      taken <= 1'h0;
      taken_vector <= 16'h0000;
    end
    else
    begin
      irq_ack <= 1'h0;
      irq_return <= 1'h0;
      taken <= 1'h0;
      if (svc_reg != 3'h0)
      begin
        svc_reg <= svc_reg - 3'h1;
        irq_return <= (svc_reg == 3'h1);
      end
      // Acks only while the request is seen high, never beside a return
      else if (enable && irq_req && !irq_ack && !irq_return)
      begin
        wait_reg <= wait_reg + 2'h1;
        if (wait_reg == slow)
        begin
          wait_reg <= 2'h0;
          irq_ack <= 1'h1;
          taken <= 1'h1;
          taken_vector <= irq_vector;
          svc_reg <= 3'h5;
        end
      end
    end
  end
endmodule

/* isv_pin_sampler.sv */
/*
  Synchroniser and machine-cycle sampler for one external interrupt pin.
  Assumes the pin is asynchronous and the tick is a one-cycle enable.
*/
`timescale 1ns/1ns
module isv_pin_sampler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mc_tick,
  input wire logic pin,
  output logic fall,
  output logic low
);

  logic sync1_reg;
  logic sync2_reg;
  logic sample_reg;
  logic fall_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
    end
  end

  // One sample per machine cycle; high then low is a falling edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sample_reg <= 1'b1;
      fall_reg <= 1'b0;
    end
    else
    begin
      fall_reg <= mc_tick & sample_reg & ~sync2_reg;
      if (mc_tick)
      begin
        sample_reg <= sync2_reg;
      end
    end
  end

  assign fall = fall_reg;
  assign low = ~sample_reg;

endmodule

/* isv_pkg.sv */
/*
  Shared constants and carrier types of the interrupt source and vectoring block.
  Assumes one system clock; peripherals deliver one-cycle event pulses on that clock.
*/
// Overview of operation
// - Eleven sources, own flag, enable, priority, vector
// - Global enable off blocks every source
// - Each external pin selects edge or level
// - Edge: high sample then low sets flag
// - Edge flag cleared on service entry
// - Level flag follows pin, never cleared on entry
// - Timer overflow flags cleared on service entry
// - Watchdog timeout sets flag, enable gates request
// - Timer c flag cleared only by software
// - Receive and transmit flags share one vector
// - Two-wire flag requests under both enables
// - Enabled keypad pin press sets keypad flag
// - Capture flag cleared only by software
// - Brownout requests need select, enable, global
// - External a 0003h, timer a 000bh
// - External b 0013h, timer b 001bh
// - Serial 0023h, brownout 002bh
// - Two-wire 0033h, keypad 003bh
// - Timer c 0043h, watchdog 0053h
package isv_pkg;

  // ****************************************
  // Sources and vectors
  // ****************************************
  localparam int NUM_SRC = 11;
  localparam logic [3:0] SRC_EXT_A = 4'h0;
  localparam logic [3:0] SRC_TIMER_A = 4'h1;
  localparam logic [3:0] SRC_EXT_B = 4'h2;
  localparam logic [3:0] SRC_TIMER_B = 4'h3;
  localparam logic [3:0] SRC_SERIAL = 4'h4;
  localparam logic [3:0] SRC_BROWNOUT = 4'h5;
  localparam logic [3:0] SRC_TWO_WIRE = 4'h6;
  localparam logic [3:0] SRC_KEYPAD = 4'h7;
  localparam logic [3:0] SRC_TIMER_C = 4'h8;
  localparam logic [3:0] SRC_CAPTURE = 4'h9;
  localparam logic [3:0] SRC_WATCHDOG = 4'ha;

  localparam logic [15:0] VEC_EXT_A = 16'h0003;
  localparam logic [15:0] VEC_TIMER_A = 16'h000b;
  localparam logic [15:0] VEC_EXT_B = 16'h0013;
  localparam logic [15:0] VEC_TIMER_B = 16'h001b;
  localparam logic [15:0] VEC_SERIAL = 16'h0023;
  localparam logic [15:0] VEC_BROWNOUT = 16'h002b;
  localparam logic [15:0] VEC_TWO_WIRE = 16'h0033;
  localparam logic [15:0] VEC_KEYPAD = 16'h003b;
  localparam logic [15:0] VEC_TIMER_C = 16'h0043;
  // Capture has no printed slot; it takes the free one below the watchdog
  localparam logic [15:0] VEC_CAPTURE = 16'h004b;
  localparam logic [15:0] VEC_WATCHDOG = 16'h0053;

  // ****************************************
  // Timing and reset values
  // ****************************************
  localparam int MC_CLKS = 4;
  localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);
  localparam logic [3:0] IN_SERVICE_RST = 4'h0;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic timer_a_overflow;
    logic timer_b_overflow;
    logic timer_c_event;
    logic watchdog_timeout;
    logic receive_done;
    logic transmit_done;
    logic two_wire_state_new;
    logic capture_event;
  } isv_events_t;

  typedef struct packed {
    logic ext_a_request_flag;
    logic ext_b_request_flag;
    logic timer_a_overflow_flag;
    logic timer_b_overflow_flag;
    logic timer_c_request_flag;
    logic watchdog_timeout_flag;
    logic receive_done_flag;
    logic transmit_done_flag;
    logic two_wire_state_flag;
    logic keypad_flag;
    logic capture_event_flag;
    logic brownout_flag;
  } isv_flags_t;

  localparam isv_flags_t FLAGS_RST = '0;

endpackage

/* isv_top.sv */
/*
  Interrupt request flags, enables, four-level arbitration and vectoring.
  Assumes the core pulses IRQ_ACK while IRQ_REQ is high and IRQ_RETURN on exit.
*/
`timescale 1ns/1ns
module isv_top (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic EXT_IRQ_PIN_A,
  input wire logic EXT_IRQ_PIN_B,
  input wire logic EXT_A_TRIGGER_TYPE,
  input wire logic EXT_B_TRIGGER_TYPE,
  input isv_pkg::isv_events_t EVENTS,
  input wire logic [7:0] KEYPAD_PINS,
  input wire logic [7:0] KEYPAD_PIN_ENABLE,
  input wire logic BROWNOUT_DETECT,
  input isv_pkg::isv_flags_t FLAG_CLEAR,
  input wire logic [10:0] SOURCE_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic BROWNOUT_IRQ_SELECT,
  input wire logic [10:0] PRIORITY_LOW,
  input wire logic [10:0] PRIORITY_HIGH,
  input wire logic IRQ_ACK,
  input wire logic IRQ_RETURN,
  output isv_pkg::isv_flags_t FLAGS,
  output logic IRQ_REQ,
  output logic [15:0] IRQ_VECTOR,
  output logic [3:0] IRQ_SOURCE,
  output logic [1:0] IRQ_LEVEL,
  output logic [3:0] IN_SERVICE
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic set_wins(input logic flag, input logic set, input logic clr);
    set_wins = set | (flag & ~clr);
  endfunction

  function automatic logic [15:0] vector_of(input logic [3:0] src);
    case (src)
      isv_pkg::SRC_EXT_A: vector_of = isv_pkg::VEC_EXT_A;
      isv_pkg::SRC_TIMER_A: vector_of = isv_pkg::VEC_TIMER_A;
      isv_pkg::SRC_EXT_B: vector_of = isv_pkg::VEC_EXT_B;
      isv_pkg::SRC_TIMER_B: vector_of = isv_pkg::VEC_TIMER_B;
      isv_pkg::SRC_SERIAL: vector_of = isv_pkg::VEC_SERIAL;
      isv_pkg::SRC_BROWNOUT: vector_of = isv_pkg::VEC_BROWNOUT;
      isv_pkg::SRC_TWO_WIRE: vector_of = isv_pkg::VEC_TWO_WIRE;
      isv_pkg::SRC_KEYPAD: vector_of = isv_pkg::VEC_KEYPAD;
      isv_pkg::SRC_TIMER_C: vector_of = isv_pkg::VEC_TIMER_C;
      isv_pkg::SRC_CAPTURE: vector_of = isv_pkg::VEC_CAPTURE;
      isv_pkg::SRC_WATCHDOG: vector_of = isv_pkg::VEC_WATCHDOG;
      default: vector_of = isv_pkg::VEC_EXT_A;
    endcase
  endfunction

  function automatic logic [1:0] level_of(input logic [3:0] src, input logic [10:0] hi,
                                          input logic [10:0] lo);
    level_of = {hi[src], lo[src]};
  endfunction

  // ****************************************
  // Machine cycle divider
  // ****************************************
  logic [3:0] mc_cnt_reg;
  logic mc_tick;

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      mc_cnt_reg <= 4'h0;
    else if (mc_tick)
      mc_cnt_reg <= 4'h0;
    else
      mc_cnt_reg <= mc_cnt_reg + 4'h1;
  end

  assign mc_tick = (mc_cnt_reg == isv_pkg::MC_LAST);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic fall_a;
  logic low_a;
  logic fall_b;
  logic low_b;
  logic [7:0] kp_s1_reg;
  logic [7:0] kp_s2_reg;
  logic [7:0] kp_s3_reg;
  logic [7:0] kp_press;
  logic bo_s1_reg;
  logic bo_s2_reg;

  // Pin timing is the far party's duty; narrower pulses may be missed
  isv_pin_sampler u_pin_a (
    .clk(CLOCK),
    .rst_n(RST_N),
    .mc_tick(mc_tick),
    .pin(EXT_IRQ_PIN_A),
    .fall(fall_a),
    .low(low_a)
  );

  isv_pin_sampler u_pin_b (
    .clk(CLOCK),
    .rst_n(RST_N),
    .mc_tick(mc_tick),
    .pin(EXT_IRQ_PIN_B),
    .fall(fall_b),
    .low(low_b)
  );

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      kp_s1_reg <= 8'hff;
      kp_s2_reg <= 8'hff;
      kp_s3_reg <= 8'hff;
      bo_s1_reg <= 1'b0;
      bo_s2_reg <= 1'b0;
    end
    else
    begin
      kp_s1_reg <= KEYPAD_PINS;
      kp_s2_reg <= kp_s1_reg;
      kp_s3_reg <= kp_s2_reg;
      bo_s1_reg <= BROWNOUT_DETECT;
      bo_s2_reg <= bo_s1_reg;
    end
  end

  // A press pulls a pin low; only enabled pins count
  assign kp_press = kp_s3_reg & ~kp_s2_reg & KEYPAD_PIN_ENABLE;

  // ****************************************
  // Request flags
  // ****************************************
  isv_pkg::isv_flags_t flags_reg;
  logic [3:0] src_reg;
  logic [1:0] lvl_reg;
  logic req_reg;
  logic take;
  logic ack_ext_a;
  logic ack_ext_b;
  logic ack_tmr_a;
  logic ack_tmr_b;

  assign take = IRQ_ACK & req_reg;
  assign ack_ext_a = take & (src_reg == isv_pkg::SRC_EXT_A) & EXT_A_TRIGGER_TYPE;
  assign ack_ext_b = take & (src_reg == isv_pkg::SRC_EXT_B) & EXT_B_TRIGGER_TYPE;
  assign ack_tmr_a = take & (src_reg == isv_pkg::SRC_TIMER_A);
  assign ack_tmr_b = take & (src_reg == isv_pkg::SRC_TIMER_B);

  // A set in the same cycle as a clear always survives
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      flags_reg <= isv_pkg::FLAGS_RST;
    else
    begin
      // Trigger type 1 is edge, 0 is level
      if (EXT_A_TRIGGER_TYPE)
        flags_reg.ext_a_request_flag <= set_wins(flags_reg.ext_a_request_flag, fall_a,
          FLAG_CLEAR.ext_a_request_flag | ack_ext_a);
      else
        flags_reg.ext_a_request_flag <= low_a;
      if (EXT_B_TRIGGER_TYPE)
        flags_reg.ext_b_request_flag <= set_wins(flags_reg.ext_b_request_flag, fall_b,
          FLAG_CLEAR.ext_b_request_flag | ack_ext_b);
      else
        flags_reg.ext_b_request_flag <= low_b;
      flags_reg.timer_a_overflow_flag <= set_wins(flags_reg.timer_a_overflow_flag,
        EVENTS.timer_a_overflow, FLAG_CLEAR.timer_a_overflow_flag | ack_tmr_a);
      flags_reg.timer_b_overflow_flag <= set_wins(flags_reg.timer_b_overflow_flag,
        EVENTS.timer_b_overflow, FLAG_CLEAR.timer_b_overflow_flag | ack_tmr_b);
      flags_reg.timer_c_request_flag <= set_wins(flags_reg.timer_c_request_flag,
        EVENTS.timer_c_event, FLAG_CLEAR.timer_c_request_flag);
      flags_reg.watchdog_timeout_flag <= set_wins(flags_reg.watchdog_timeout_flag,
        EVENTS.watchdog_timeout, FLAG_CLEAR.watchdog_timeout_flag);
      flags_reg.receive_done_flag <= set_wins(flags_reg.receive_done_flag,
        EVENTS.receive_done, FLAG_CLEAR.receive_done_flag);
      flags_reg.transmit_done_flag <= set_wins(flags_reg.transmit_done_flag,
        EVENTS.transmit_done, FLAG_CLEAR.transmit_done_flag);
      flags_reg.two_wire_state_flag <= set_wins(flags_reg.two_wire_state_flag,
        EVENTS.two_wire_state_new, FLAG_CLEAR.two_wire_state_flag);
      flags_reg.keypad_flag <= set_wins(flags_reg.keypad_flag, |kp_press,
        FLAG_CLEAR.keypad_flag);
      flags_reg.capture_event_flag <= set_wins(flags_reg.capture_event_flag,
        EVENTS.capture_event, FLAG_CLEAR.capture_event_flag);
      flags_reg.brownout_flag <= set_wins(flags_reg.brownout_flag, bo_s2_reg,
        FLAG_CLEAR.brownout_flag);
    end
  end

  // ****************************************
  // Arbitration
  // ****************************************
  logic [10:0] src_flag;
  logic [10:0] pend;
  logic [10:0] same_lvl;
  logic found;
  logic [3:0] best_idx;
  logic [1:0] best_lvl;
  logic [3:0] ins_reg;
  logic act_valid;
  logic [1:0] act_lvl;
  logic win;

  always_comb
  begin
    src_flag = 11'h000;
    src_flag[isv_pkg::SRC_EXT_A] = flags_reg.ext_a_request_flag;
    src_flag[isv_pkg::SRC_TIMER_A] = flags_reg.timer_a_overflow_flag;
    src_flag[isv_pkg::SRC_EXT_B] = flags_reg.ext_b_request_flag;
    src_flag[isv_pkg::SRC_TIMER_B] = flags_reg.timer_b_overflow_flag;
    src_flag[isv_pkg::SRC_SERIAL] = flags_reg.receive_done_flag
      | flags_reg.transmit_done_flag;
    src_flag[isv_pkg::SRC_BROWNOUT] = flags_reg.brownout_flag & BROWNOUT_IRQ_SELECT;
    src_flag[isv_pkg::SRC_TWO_WIRE] = flags_reg.two_wire_state_flag;
    src_flag[isv_pkg::SRC_KEYPAD] = flags_reg.keypad_flag;
    src_flag[isv_pkg::SRC_TIMER_C] = flags_reg.timer_c_request_flag;
    src_flag[isv_pkg::SRC_CAPTURE] = flags_reg.capture_event_flag;
    src_flag[isv_pkg::SRC_WATCHDOG] = flags_reg.watchdog_timeout_flag;
  end

  assign pend = src_flag & SOURCE_ENABLE & {11{GLOBAL_IRQ_ENABLE}};

  // Strictly greater keeps the lowest vector among equal levels
  always_comb
  begin
    found = 1'b0;
    best_idx = 4'h0;
    best_lvl = 2'h0;
    for (int i = 0; i < isv_pkg::NUM_SRC; i++)
    begin
      if (pend[i] && (!found || level_of(4'(i), PRIORITY_HIGH, PRIORITY_LOW) > best_lvl))
      begin
        found = 1'b1;
        best_idx = 4'(i);
        best_lvl = level_of(4'(i), PRIORITY_HIGH, PRIORITY_LOW);
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < isv_pkg::NUM_SRC; i++)
      same_lvl[i] = pend[i] && (level_of(4'(i), PRIORITY_HIGH, PRIORITY_LOW) == best_lvl);
  end

  assign act_valid = |ins_reg;
  assign act_lvl = ins_reg[3] ? 2'h3 : ins_reg[2] ? 2'h2 : ins_reg[1] ? 2'h1 : 2'h0;
  // Only a higher level may interrupt a running routine
  assign win = found && (!act_valid || best_lvl > act_lvl);

  // Request drops for one cycle after a take so the next pick sees fresh flags
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      req_reg <= 1'b0;
      src_reg <= 4'h0;
      lvl_reg <= 2'h0;
    end
    else
    begin
      req_reg <= win & ~IRQ_ACK;
      src_reg <= best_idx;
      lvl_reg <= best_lvl;
    end
  end

  logic [15:0] vec_reg;

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      vec_reg <= isv_pkg::VEC_EXT_A;
    else
      vec_reg <= vector_of(best_idx);
  end

  // ****************************************
  // In-service levels
  // ****************************************
  logic [3:0] ins_next;

  always_comb
  begin
    ins_next = ins_reg;
    if (IRQ_RETURN)
      ins_next[act_lvl] = 1'b0;
    if (take)
      ins_next[lvl_reg] = 1'b1;
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      ins_reg <= isv_pkg::IN_SERVICE_RST;
    else
      ins_reg <= ins_next;
  end

  assign FLAGS = flags_reg;
  assign IRQ_REQ = req_reg;
  assign IRQ_VECTOR = vec_reg;
  assign IRQ_SOURCE = src_reg;
  assign IRQ_LEVEL = lvl_reg;
  assign IN_SERVICE = ins_reg;

  // ****************************************
  // Assertions
  // ****************************************
  property p_edge_set;
    @(posedge CLOCK) disable iff (!RST_N)
      (fall_a && EXT_A_TRIGGER_TYPE) |=> flags_reg.ext_a_request_flag;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge did not set flag");

  property p_edge_clr;
    @(posedge CLOCK) disable iff (!RST_N)
      (ack_ext_a && !fall_a && $stable(EXT_A_TRIGGER_TYPE)) |=> !flags_reg.ext_a_request_flag;
  endproperty
  a_edge_clr: assert property (p_edge_clr) else $error("edge flag kept on entry");

  property p_level_follow;
    @(posedge CLOCK) disable iff (!RST_N)
      (!EXT_B_TRIGGER_TYPE && low_b) |=> flags_reg.ext_b_request_flag;
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level flag lost");

  property p_timer_clr;
    @(posedge CLOCK) disable iff (!RST_N)
      (ack_tmr_b && !EVENTS.timer_b_overflow) |=> !flags_reg.timer_b_overflow_flag;
  endproperty
  a_timer_clr: assert property (p_timer_clr) else $error("timer flag kept");

  property p_sw_only;
    @(posedge CLOCK) disable iff (!RST_N)
      (flags_reg.timer_c_request_flag && !FLAG_CLEAR.timer_c_request_flag)
        |=> flags_reg.timer_c_request_flag;
  endproperty
  a_sw_only: assert property (p_sw_only) else $error("timer c flag lost");

  property p_wd_set;
    @(posedge CLOCK) disable iff (!RST_N)
      EVENTS.watchdog_timeout |=> flags_reg.watchdog_timeout_flag ##1
        (flags_reg.watchdog_timeout_flag || $past(FLAG_CLEAR.watchdog_timeout_flag));
  endproperty
  a_wd_set: assert property (p_wd_set) else $error("watchdog flag wrong");

  property p_global;
    @(posedge CLOCK) disable iff (!RST_N)
      !GLOBAL_IRQ_ENABLE |=> !IRQ_REQ;
  endproperty
  a_global: assert property (p_global) else $error("request while disabled");

  property p_two_wire;
    @(posedge CLOCK) disable iff (!RST_N)
      (IRQ_REQ && IRQ_SOURCE == isv_pkg::SRC_TWO_WIRE)
        |-> $past(SOURCE_ENABLE[isv_pkg::SRC_TWO_WIRE] & flags_reg.two_wire_state_flag);
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("two-wire not enabled");

  property p_brownout;
    @(posedge CLOCK) disable iff (!RST_N)
      (IRQ_REQ && IRQ_SOURCE == isv_pkg::SRC_BROWNOUT) |-> $past(BROWNOUT_IRQ_SELECT);
  endproperty
  a_brownout: assert property (p_brownout) else $error("brownout not selected");

  property p_vector;
    @(posedge CLOCK) disable iff (!RST_N)
      IRQ_REQ |-> (IRQ_VECTOR[2:0] == 3'h3 && IRQ_VECTOR[15:3] == {9'h000, IRQ_SOURCE});
  endproperty
  a_vector: assert property (p_vector) else $error("vector mismatch");

  property p_lowest;
    @(posedge CLOCK) disable iff (!RST_N)
      IRQ_REQ |-> ($past(same_lvl) & 11'((11'h001 << IRQ_SOURCE) - 11'h001)) == 11'h000;
  endproperty
  a_lowest: assert property (p_lowest) else $error("lower vector skipped");

  property p_push;
    @(posedge CLOCK) disable iff (!RST_N)
      (take && !IRQ_RETURN) |=> IN_SERVICE[$past(lvl_reg)] ##1 !IRQ_REQ || IRQ_LEVEL > 2'h0;
  endproperty
  a_push: assert property (p_push) else $error("level not marked");

  c_take: cover property (@(posedge CLOCK) disable iff (!RST_N) take);
  c_nest: cover property (@(posedge CLOCK) disable iff (!RST_N) take && act_valid);
  c_keypad: cover property (@(posedge CLOCK) disable iff (!RST_N) |kp_press);
  c_ret: cover property (@(posedge CLOCK) disable iff (!RST_N) IRQ_RETURN && ins_reg[1]);

endmodule

/* isv_top_test.sv */
/*
  Self-checking bench of the interrupt source and vectoring block.
  Assumes the core model answers requests; peripheral events are driven here.
*/
`timescale 1ns/1ns
module isv_top_test;
  // ****************
  // Signals
  // ****************
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic pin_a = 1'h1;
  logic pin_b = 1'h1;
  logic trig_a = 1'h1;
  logic trig_b = 1'h1;
  isv_pkg::isv_events_t events = '0;
  logic [7:0] key_pins = 8'hff;
  logic [7:0] key_en = 8'h00;
  logic brown_det = 1'h0;
  isv_pkg::isv_flags_t flag_clear = '0;
  logic [10:0] src_en = 11'h000;
  logic global_en = 1'h0;
  logic brown_sel = 1'h0;
  logic [10:0] pri_lo = 11'h000;
  logic [10:0] pri_hi = 11'h000;
  logic core_en = 1'h0;
  logic [1:0] core_slow = 2'h0;
  logic irq_ack;
  logic irq_return;
  logic taken;
  logic [15:0] taken_vec;
  isv_pkg::isv_flags_t flags;
  logic irq_req;
  logic [15:0] irq_vector;
  logic [3:0] in_service;
  logic [3:0] irq_src;
  logic [1:0] irq_lvl;
  int errors = 0;
  int checks = 0;
  logic [31:0] rnd = 32'he882f32e;
  logic [15:0] v;
  logic [15:0] e;
  logic tx;
  logic [1:0] lvl;

  always #5 clock = ~clock;

  isv_top i_isv_top (
    .CLOCK(clock), .RST_N(rst_n), .EXT_IRQ_PIN_A(pin_a), .EXT_IRQ_PIN_B(pin_b),
    .EXT_A_TRIGGER_TYPE(trig_a), .EXT_B_TRIGGER_TYPE(trig_b), .EVENTS(events),
    .KEYPAD_PINS(key_pins), .KEYPAD_PIN_ENABLE(key_en), .BROWNOUT_DETECT(brown_det),
    .FLAG_CLEAR(flag_clear), .SOURCE_ENABLE(src_en), .GLOBAL_IRQ_ENABLE(global_en),
    .BROWNOUT_IRQ_SELECT(brown_sel), .PRIORITY_LOW(pri_lo), .PRIORITY_HIGH(pri_hi),
    .IRQ_ACK(irq_ack), .IRQ_RETURN(irq_return), .FLAGS(flags), .IRQ_REQ(irq_req),
    .IRQ_VECTOR(irq_vector), .IRQ_SOURCE(irq_src), .IRQ_LEVEL(irq_lvl),
    .IN_SERVICE(in_service));

  isv_core_model i_isv_core_model (
    .clk(clock), .rst_n(rst_n), .enable(core_en), .slow(core_slow), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_return(irq_return), .taken(taken),
    .taken_vector(taken_vec));

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] vec_for(int s);
    return 16'h0003 + 16'(s * 8);
  endfunction

  function automatic isv_pkg::isv_flags_t flag_for(int s, logic t);
    isv_pkg::isv_flags_t f;
    f = isv_pkg::FLAGS_RST;
    case (s)
      0: f.ext_a_request_flag = 1'h1;
      1: f.timer_a_overflow_flag = 1'h1;
      2: f.ext_b_request_flag = 1'h1;
      3: f.timer_b_overflow_flag = 1'h1;
      4: {f.transmit_done_flag, f.receive_done_flag} = t ? 2'h2 : 2'h1;
      5: f.brownout_flag = 1'h1;
      6: f.two_wire_state_flag = 1'h1;
      7: f.keypad_flag = 1'h1;
      8: f.timer_c_request_flag = 1'h1;
      9: f.capture_event_flag = 1'h1;
      default: f.watchdog_timeout_flag = 1'h1;
    endcase
    return f;
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Pins stay low until restored, so each level lasts several machine cycles
  task automatic fire(int s, logic t, logic [2:0] k);
    key_en = 8'h01 << k;
    case (s)
      0: pin_a = 1'h0;
      1: events.timer_a_overflow = 1'h1;
      2: pin_b = 1'h0;
      3: events.timer_b_overflow = 1'h1;
      4: {events.transmit_done, events.receive_done} = t ? 2'h2 : 2'h1;
      5: brown_det = 1'h1;
      6: events.two_wire_state_new = 1'h1;
      7: key_pins[k] = 1'h0;
      8: events.timer_c_event = 1'h1;
      9: events.capture_event = 1'h1;
      default: events.watchdog_timeout = 1'h1;
    endcase
    tick(1);
    events = '0;
  endtask

  task automatic wait_taken(output logic [15:0] got);
    got = 16'hffff;
    repeat (100)
    begin
      tick(1);
      if (taken === 1'h1)
      begin
        got = taken_vec;
        return;
      end
    end
  endtask

  task automatic wrap_up();
    $display("Counts: %0d checks, %0d errors", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  initial
  begin
    tick(4);
    rst_n = 1'h1;
    tick(2);
    for (int s = 0; s < 11; s++)
    begin
      rnd = lfsr(rnd);
      tx = rnd[4];
      lvl = rnd[1:0];
      pri_lo[s] = lvl[0];
      pri_hi[s] = lvl[1];
      core_slow = rnd[3:2];
      global_en = 1'h0;
      src_en = 11'h7ff;
      fire(s, tx, rnd[7:5]);
      tick(16);
      check("set", 16'(flag_for(s, tx)), 16'(flags));
      check("global off", 16'h0, 16'(irq_req));
      // Brownout keeps its enable but loses its select bit instead
      src_en = (s == 5) ? 11'h7ff : ~(11'h001 << s);
      brown_sel = (s != 5);
      global_en = 1'h1;
      tick(8);
      check("own enable off", 16'h0, 16'(irq_req));
      src_en = 11'h001 << s;
      brown_sel = 1'h1;
      tick(2);
      check("offered", 16'h1, 16'(irq_req));
      check("source", 16'(s), 16'(irq_src));
      check("level", 16'(lvl), 16'(irq_lvl));
      check("offered vector", vec_for(s), irq_vector);
      core_en = 1'h1;
      wait_taken(v);
      global_en = 1'h0;
      core_en = 1'h0;
      check("vector", vec_for(s), v);
      tick(1);
      check("in service", 16'h1 << lvl, 16'(in_service));
      tick(8);
      check("returned", 16'h0, 16'(in_service));
      e = s < 4 ? 16'h0 : 16'(flag_for(s, tx));
      check("kept", e, 16'(flags));
      pin_a = 1'h1;
      pin_b = 1'h1;
      brown_det = 1'h0;
      key_pins = 8'hff;
      tick(8);
      flag_clear = flag_for(s, tx);
      tick(1);
      flag_clear = '0;
      tick(2);
      check("cleared", 16'h0, 16'(flags));
    end
    // Level mode: a pin still low after the routine asks again
    trig_a = 1'h0;
    trig_b = 1'h0;
    src_en = 11'h001;
    global_en = 1'h1;
    core_en = 1'h1;
    pin_a = 1'h0;
    pin_b = 1'h0;
    wait_taken(v);
    check("level vector", 16'h0003, v);
    wait_taken(v);
    check("level again", 16'h0003, v);
    core_en = 1'h0;
    tick(8);
    check("level flag", 16'h1, 16'(flags.ext_a_request_flag));
    check("level flag b", 16'h1, 16'(flags.ext_b_request_flag));
    pin_a = 1'h1;
    pin_b = 1'h1;
    tick(16);
    check("level gone", 16'h0, 16'(flags));
    trig_a = 1'h1;
    trig_b = 1'h1;
    // Two timers at once: higher level first, else the lower vector
    for (int k = 0; k < 2; k++)
    begin
      pri_lo = 11'h000;
      pri_hi = {7'h00, k == 0, 3'h0};
      src_en = 11'h00a;
      core_en = 1'h1;
      events.timer_a_overflow = 1'h1;
      events.timer_b_overflow = 1'h1;
      tick(1);
      events = '0;
      wait_taken(v);
      check("first", k == 0 ? 16'h001b : 16'h000b, v);
      wait_taken(v);
      check("second", k == 0 ? 16'h000b : 16'h001b, v);
      tick(8);
    end
    wrap_up();
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    errors++;
    wrap_up();
  end
endmodule
